// File: hw/fracn_pkg.sv
// Package for the fractional-N feedback loop control block.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package fracn_pkg;

  // Register byte offsets
  localparam logic [5:0] status_off = 6'h00;
  localparam logic [5:0] pump_ctrl_off = 6'h04;
  localparam logic [5:0] mod_ctrl_off = 6'h08;
  localparam logic [5:0] divide_off = 6'h0c;
  localparam logic [5:0] numer_off = 6'h10;
  localparam logic [5:0] seed_off = 6'h14;
  localparam logic [5:0] pump_out_off = 6'h18;

  // Pump control field positions
  localparam int cur_lsb = 0;
  localparam int inv_bit = 3;
  localparam int chi_bit = 4;
  localparam int clo_bit = 5;
  localparam int mid_bit = 6;
  localparam int rst_bit = 7;
  localparam int up_bit = 8;
  localparam int dn_bit = 9;
  localparam int wide_bit = 10;
  localparam int le_bit = 11;

  // Modulator control field positions
  localparam int integer_mode_select_bit = 0;
  localparam int dith_bit = 1;
  localparam int auto_bit = 2;
  localparam int mrst_bit = 3;

  // Reset values: dither enabled, auto reset enabled
  localparam logic [3:0] mod_ctrl_rst = 4'h6;
  localparam logic [11:0] pump_ctrl_rst = 12'h007;
  localparam logic [9:0] divide_rst = 10'h064;
  localparam logic [17:0] numer_rst = 18'h00001;
  localparam logic [17:0] seed_rst = 18'h00001;

  // Divider limits
  localparam logic [9:0] div_min_int = 10'h020;
  localparam logic [9:0] div_max_int = 10'h3ff;
  localparam logic [17:0] numer_max = 18'h3ffff;
  localparam int frac_bits = 18;

  // Pump current in units of 0.1 mA
  localparam logic [6:0] pump_tenth_ma [8] = '{7'h0a, 7'h0e, 7'h14, 7'h1c,
    7'h28, 7'h38, 7'h50, 7'h70};

  typedef struct packed {
    logic source_on;
    logic sink_on;
    logic detector_hold;
    logic delay_long;
    logic lin_on;
    logic bias_on;
    logic [6:0] mag;
  } pump_drive_type;

  typedef struct packed {
    logic up;
    logic down;
  } detector_type;

endpackage

// File: hw/fracn_mod.sv
// Error-feedback modulator with LFSR dither, one step per comparison edge.
// Assumes step is a one-cycle pulse at the comparison rate.
`timescale 1ns/1ns
module fracn_mod #(
  parameter int W = 18
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic step,
  input wire logic standby,
  input wire logic init,
  input wire logic dither_enable,
  input wire logic [W-1:0] numer,
  input wire logic [W-1:0] seed,
  output logic carry
);

  logic [W-1:0] acc_reg;
  logic [W-1:0] lfsr_reg;
  logic [W:0] sum;
  logic [W-1:0] dith;

  // Dither is zero or one LSB of noise, raising the mean fraction by about half an LSB
  assign dith = (dither_enable && lfsr_reg[0]) ? W'(1) : '0;
  assign sum = {1'b0, acc_reg} + {1'b0, numer} + {1'b0, dith};

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_reg <= '0;
      carry <= 1'b0;
    end else if (init) begin
      acc_reg <= '0;
      carry <= 1'b0;
    end else if (step && !standby) begin
      acc_reg <= sum[W-1:0];
      carry <= sum[W];
    end else if (standby) begin
      carry <= 1'b0;
    end
  end

  // Seed loads on init so the dither pattern repeats after each reset
  always_ff @(posedge clock) begin
    if (srst) begin
      lfsr_reg <= W'(1);
    end else if (init) begin
      lfsr_reg <= (seed == '0) ? W'(1) : seed;
    end else if (step && !standby) begin
      lfsr_reg <= {lfsr_reg[W-2:0], lfsr_reg[W-1] ^ lfsr_reg[10]};
    end
  end

endmodule

// File: hw/fracn_loop_control.sv
// Control logic for the feedback path of a fractional-N loop: pump control,
// clamp flags, feedback divider and its modulator, with an Avalon-MM slave.
// Assumes vco_tick pulses once per VCO cycle in the clock domain and
// ref_tick once per reference comparison cycle.
// Contract
// - Pump code 0..7 selects 1.0 to 11.2 mA magnitudes.
// - Phase invert swaps detector up and down senses.
// - High clamp over threshold sets flag and stops sourcing.
// - Low clamp under threshold sets flag and stops sinking.
// - Force bits drive constant source or sink current.
// - Pulse widen lengthens detector reset path delay.
// - Linearizer on only when enabled and not integer mode.
// - Integer mode divides by any ratio 32 through 1023.
// - Modulator steps once per comparison, mean ratio hits target.
// - Numerator is 18-bit, fraction over 262144.
// - Integer mode holds modulator in powered standby.
// - Dither enable adds pseudorandom dither, resets enabled.
// - Modulator reset bit reinitialises arithmetic then self clears.
// - Auto reset fires modulator reset on divider/numer/seed writes.
// - Programmable seed initialises dither sequence.
// - Detector reset suppresses all up and down pulses.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module fracn_loop_control #(
  parameter int ratio_bits = 10,
  parameter int frac_width = 18
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic vco_tick,
  input wire logic ref_tick,
  input wire logic over_high,
  input wire logic under_low,
  output logic div_out,
  output logic detector_up,
  output logic detector_down,
  output fracn_pkg::pump_drive_type pump_drive,
  output logic high_clamp_flag,
  output logic low_clamp_flag
);

  logic [2:0] pump_current_sel;
  logic detector_phase_invert;
  logic high_clamp_enable;
  logic low_clamp_enable;
  logic mid_supply_bias_enable;
  logic detector_reset;
  logic force_source_current;
  logic force_sink_current;
  logic pulse_widen;
  logic linearizer_enable;
  logic integer_mode_select;
  logic dither_enable;
  logic auto_modulator_reset;
  logic modulator_reset;
  logic [11:0] pump_ctrl_reg;
  logic [3:0] mod_ctrl_reg;
  logic [ratio_bits-1:0] feedback_divide_ratio;
  logic [frac_width-1:0] numer_reg;
  logic [frac_width-1:0] seed_reg;
  logic [ratio_bits-1:0] count_reg;
  logic [ratio_bits-1:0] active_ratio_reg;
  logic ref_seen_reg;
  logic step;
  logic carry;
  logic wr_hit;
  logic rd_pend_reg;
  logic [31:0] wmask;
  logic [31:0] rd_next;
  fracn_pkg::detector_type raw_det;

  assign pump_current_sel = pump_ctrl_reg[fracn_pkg::cur_lsb +: 3];
  assign detector_phase_invert = pump_ctrl_reg[fracn_pkg::inv_bit];
  assign high_clamp_enable = pump_ctrl_reg[fracn_pkg::chi_bit];
  assign low_clamp_enable = pump_ctrl_reg[fracn_pkg::clo_bit];
  assign mid_supply_bias_enable = pump_ctrl_reg[fracn_pkg::mid_bit];
  assign detector_reset = pump_ctrl_reg[fracn_pkg::rst_bit];
  assign force_source_current = pump_ctrl_reg[fracn_pkg::up_bit];
  assign force_sink_current = pump_ctrl_reg[fracn_pkg::dn_bit];
  assign pulse_widen = pump_ctrl_reg[fracn_pkg::wide_bit];
  assign linearizer_enable = pump_ctrl_reg[fracn_pkg::le_bit];
  assign integer_mode_select = mod_ctrl_reg[fracn_pkg::integer_mode_select_bit];
  assign dither_enable = mod_ctrl_reg[fracn_pkg::dith_bit];
  assign auto_modulator_reset = mod_ctrl_reg[fracn_pkg::auto_bit];
  assign modulator_reset = mod_ctrl_reg[fracn_pkg::mrst_bit];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // Writes complete in one cycle; reads take one extra wait cycle
  assign wr_hit = avs_write;
  assign avs_waitrequest = avs_read && !rd_pend_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= avs_read && !rd_pend_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pump_ctrl_reg <= fracn_pkg::pump_ctrl_rst;
    end else if (wr_hit && avs_address == fracn_pkg::pump_ctrl_off) begin
      pump_ctrl_reg <= (pump_ctrl_reg & ~wmask[11:0])
        | (avs_writedata[11:0] & wmask[11:0]);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mod_ctrl_reg <= fracn_pkg::mod_ctrl_rst;
    end else begin
      if (wr_hit && avs_address == fracn_pkg::mod_ctrl_off
          && avs_byteenable[0]) begin
        mod_ctrl_reg <= avs_writedata[3:0];
      end else begin
        mod_ctrl_reg[fracn_pkg::mrst_bit] <= 1'b0;
      end
      if (wr_hit && auto_modulator_reset
          && (avs_address == fracn_pkg::divide_off
          || avs_address == fracn_pkg::numer_off
          || avs_address == fracn_pkg::seed_off)) begin
        mod_ctrl_reg[fracn_pkg::mrst_bit] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      feedback_divide_ratio <= ratio_bits'(fracn_pkg::divide_rst);
    end else if (wr_hit && avs_address == fracn_pkg::divide_off) begin
      feedback_divide_ratio <= (feedback_divide_ratio
        & ~wmask[ratio_bits-1:0])
        | (avs_writedata[ratio_bits-1:0] & wmask[ratio_bits-1:0]);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      numer_reg <= frac_width'(fracn_pkg::numer_rst);
      seed_reg <= frac_width'(fracn_pkg::seed_rst);
    end else if (wr_hit) begin
      if (avs_address == fracn_pkg::numer_off) begin
        numer_reg <= (numer_reg & ~wmask[frac_width-1:0])
          | (avs_writedata[frac_width-1:0] & wmask[frac_width-1:0]);
      end
      if (avs_address == fracn_pkg::seed_off) begin
        seed_reg <= (seed_reg & ~wmask[frac_width-1:0])
          | (avs_writedata[frac_width-1:0] & wmask[frac_width-1:0]);
      end
    end
  end

  always_comb begin
    rd_next = 32'h00000000;
    unique case (avs_address)
      fracn_pkg::status_off: rd_next = {30'h0, high_clamp_flag,
        low_clamp_flag};
      fracn_pkg::pump_ctrl_off: rd_next = {20'h0, pump_ctrl_reg};
      fracn_pkg::mod_ctrl_off: rd_next = {28'h0, mod_ctrl_reg};
      fracn_pkg::divide_off: rd_next = 32'(feedback_divide_ratio);
      fracn_pkg::numer_off: rd_next = 32'(numer_reg);
      fracn_pkg::seed_off: rd_next = 32'(seed_reg);
      fracn_pkg::pump_out_off: rd_next = 32'(pump_drive);
      default: rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !rd_pend_reg) begin
      avs_readdata <= rd_next;
    end
  end

  // Comparison step from the reference edge
  // one step per comparison
  always_ff @(posedge clock) begin
    if (srst) begin
      ref_seen_reg <= 1'b0;
    end else begin
      ref_seen_reg <= ref_tick;
    end
  end
  assign step = ref_tick && !ref_seen_reg;

  fracn_mod #(
    .W(frac_width)
  ) u_mod (
    .clock(clock),
    .srst(srst),
    .step(step),
    .standby(integer_mode_select),
    .init(modulator_reset),
    .dither_enable(dither_enable),
    .numer(numer_reg),
    .seed(seed_reg),
    .carry(carry)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      count_reg <= '0;
      active_ratio_reg <= ratio_bits'(fracn_pkg::divide_rst);
      div_out <= 1'b0;
    end else if (vco_tick) begin
      if (count_reg <= ratio_bits'(1)) begin
        active_ratio_reg <= feedback_divide_ratio
          + ratio_bits'(carry && !integer_mode_select);
        count_reg <= feedback_divide_ratio
          + ratio_bits'(carry && !integer_mode_select);
        div_out <= 1'b1;
      end else begin
        count_reg <= count_reg - ratio_bits'(1);
        div_out <= 1'b0;
      end
    end else begin
      div_out <= 1'b0;
    end
  end

  always_comb begin
    raw_det.up = step;
    raw_det.down = div_out;
    if (detector_phase_invert) begin
      raw_det.up = div_out;
      raw_det.down = step;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || detector_reset) begin
      detector_up <= 1'b0;
      detector_down <= 1'b0;
    end else begin
      detector_up <= raw_det.up;
      detector_down <= raw_det.down;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      high_clamp_flag <= 1'b0;
      low_clamp_flag <= 1'b0;
    end else begin
      high_clamp_flag <= high_clamp_enable && over_high;
      low_clamp_flag <= low_clamp_enable && under_low;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pump_drive <= '0;
    end else begin
      pump_drive.mag <= fracn_pkg::pump_tenth_ma[pump_current_sel];
      pump_drive.source_on <= (force_source_current
        || (raw_det.up && !detector_reset))
        && !(high_clamp_enable && over_high);
      pump_drive.sink_on <= (force_sink_current
        || (raw_det.down && !detector_reset))
        && !(low_clamp_enable && under_low);
      pump_drive.detector_hold <= detector_reset;
      pump_drive.delay_long <= pulse_widen;
      pump_drive.lin_on <= linearizer_enable && !integer_mode_select;
      pump_drive.bias_on <= mid_supply_bias_enable;
    end
  end

  // Reset blocks detector pulses but never the forced currents, so a
  // pre-charge with reset plus a force bit still moves the loop

  property p_det_quiet;
    @(posedge clock) disable iff (srst)
      $past(detector_reset) |-> !detector_up && !detector_down;
  endproperty
  a_det_quiet: assert property (p_det_quiet)
    else $error("detector pulse while held in reset");

  property p_high_flag;
    @(posedge clock) disable iff (srst)
      high_clamp_enable && over_high |=> high_clamp_flag
        && !pump_drive.source_on;
  endproperty
  a_high_flag: assert property (p_high_flag)
    else $error("high clamp did not flag or stop source");

  property p_low_flag;
    @(posedge clock) disable iff (srst)
      low_clamp_enable && under_low |=> low_clamp_flag
        && !pump_drive.sink_on;
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("low clamp did not flag or stop sink");

  property p_lin;
    @(posedge clock) disable iff (srst)
      ##1 pump_drive.lin_on |-> $past(linearizer_enable)
        && !$past(integer_mode_select);
  endproperty
  a_lin: assert property (p_lin)
    else $error("linearizer on without enable or in integer mode");

  property p_mrst_clear;
    @(posedge clock) disable iff (srst)
      modulator_reset && !avs_write |=> !modulator_reset;
  endproperty
  a_mrst_clear: assert property (p_mrst_clear)
    else $error("modulator reset did not clear itself");

  property p_auto;
    @(posedge clock) disable iff (srst)
      avs_write && auto_modulator_reset
        && avs_address == fracn_pkg::numer_off |=> modulator_reset;
  endproperty
  a_auto: assert property (p_auto)
    else $error("numerator write did not trigger modulator reset");

  property p_mag;
    @(posedge clock) disable iff (srst)
      pump_current_sel == 3'h7 ##1 pump_current_sel == 3'h7
        |-> pump_drive.mag == 7'h70;
  endproperty
  a_mag: assert property (p_mag)
    else $error("code 7 did not give 11.2 mA");

  property p_force;
    @(posedge clock) disable iff (srst)
      force_source_current && !(high_clamp_enable && over_high)
        |=> pump_drive.source_on;
  endproperty
  a_force: assert property (p_force)
    else $error("forced source current missing");

endmodule

// File: verification/fracn_loop_partner.sv
// Loop filter and VCO model: integrates pump drive, reports clamp levels.
// Assumes one clock domain and a registered pump drive from the block.
`timescale 1ns/1ns
module fracn_loop_partner #(
  parameter int slow = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire fracn_pkg::pump_drive_type pump_drive,
  output logic vco_tick,
  output logic over_high,
  output logic under_low
);
  int volt;
  logic [1:0] phase;

  always_ff @(posedge clock) begin
    if (srst) begin
      volt <= 500;
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      if (pump_drive.source_on && !pump_drive.sink_on && volt < 1000)
        volt <= volt + 1;
      else if (pump_drive.sink_on && !pump_drive.source_on && volt > 0)
        volt <= volt - 1;
      else if (pump_drive.bias_on && volt != 500)
        volt <= (volt > 500) ? volt - 1 : volt + 1;
    end
  end

  // A slow oscillator skips one edge in four, so counts are not cycles
  assign vco_tick = !srst && (slow == 0 || phase != 2'h3);
  // Comparators trip at a tenth of the range from each rail
  assign over_high = volt > 900;
  assign under_low = volt < 100;
endmodule

// File: verification/fracn_loop_control_test.sv
// Self-checking bench for the fractional-N loop control block.
// Assumes the partner model drives the VCO and comparator inputs.
`timescale 1ns/1ns
`define CHK(act, exp) begin \
  n_checks++; \
  if ((act) !== (exp)) begin \
    n_mismatch++; \
    $display("[FAIL] %0t act %h exp %h", $time, (act), (exp)); \
  end \
end
module fracn_loop_control_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic vco_tick, over_high, under_low, div_out, detector_up, detector_down;
  logic ref_tick = 1'b0;
  logic ref_free = 1'b1;
  logic high_clamp_flag, low_clamp_flag;
  fracn_pkg::pump_drive_type pump_drive;
  int n_mismatch = 0;
  int n_checks = 0;
  int rcnt = 0;
  int tcnt = 0;
  logic tick_d = 1'b0;
  int per[$];
  int n_up = 0;
  int n_dn = 0;
  int tenth[8] = '{10, 14, 20, 28, 40, 56, 80, 112};

  fracn_loop_control uut (.clock(clock), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .vco_tick(vco_tick), .ref_tick(ref_tick), .over_high(over_high),
    .under_low(under_low), .div_out(div_out), .detector_up(detector_up),
    .detector_down(detector_down), .pump_drive(pump_drive),
    .high_clamp_flag(high_clamp_flag), .low_clamp_flag(low_clamp_flag));
  fracn_loop_partner far_side (.clock(clock), .srst(srst),
    .pump_drive(pump_drive), .vco_tick(vco_tick), .over_high(over_high),
    .under_low(under_low));

  initial begin
    forever #2 clock = ~clock;
  end

  // Reference either free runs or follows the divider, as in a locked loop
  always @(posedge clock) begin
    rcnt <= (rcnt == 39) ? 0 : rcnt + 1;
    ref_tick <= ref_free ? (rcnt == 0) : (div_out === 1'b1);
  end

  // Divider periods in VCO ticks; the tick is delayed to match div_out
  always @(posedge clock) begin
    if (div_out === 1'b1) begin
      per.push_back(tcnt + tick_d);
      tcnt = 0;
    end else tcnt = tcnt + tick_d;
    tick_d = (vco_tick === 1'b1);
    n_up += (detector_up === 1'b1);
    n_dn += (detector_down === 1'b1);
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("[FAIL] %0t act %h exp %h", $time, 0, 1);
    end_of_test();
  endtask

  task automatic bus(input logic rd, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 40) timeout();
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    `CHK(q, e)
  endtask

  task automatic wait_high(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim && s !== 1'b1; i++) @(posedge clock);
    if (s !== 1'b1) timeout();
  endtask

  task automatic grab(input int n);
    int i;
    per.delete();
    for (i = 0; i < 40000 && per.size() < n; i++) @(posedge clock);
    if (per.size() < n) timeout();
  endtask

  initial begin
    int i, j, r, n, s, e;
    int seqa[$];
    real ex;
    void'($urandom(32'h78f1));
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rdchk(fracn_pkg::pump_ctrl_off, 32'h7);
    rdchk(fracn_pkg::mod_ctrl_off, 32'h6);
    rdchk(fracn_pkg::numer_off, 32'h1);
    rdchk(fracn_pkg::seed_off, 32'h1);
    wr(6'h1c, 32'h5a);
    rdchk(6'h1c, 32'h0);
    for (i = 0; i < 8; i++) begin
      wr(fracn_pkg::pump_ctrl_off, 32'h100 | i);
      repeat (3) @(posedge clock);
      `CHK(pump_drive.mag, 7'(tenth[i]))
      `CHK({pump_drive.source_on, pump_drive.sink_on}, 2'b10)
    end
    wr(fracn_pkg::pump_ctrl_off, 32'h205);
    repeat (3) @(posedge clock);
    `CHK({pump_drive.source_on, pump_drive.sink_on}, 2'b01)
    // mid bias paired with detector reset
    wr(fracn_pkg::pump_ctrl_off, 32'h4c0);
    n_up = 0;
    n_dn = 0;
    repeat (400) @(posedge clock);
    `CHK(n_up + n_dn, 0)
    `CHK({pump_drive.detector_hold, pump_drive.bias_on}, 2'b11)
    `CHK(pump_drive.delay_long, 1'b1)
    wr(fracn_pkg::pump_ctrl_off, 32'h800);
    repeat (3) @(posedge clock);
    `CHK(pump_drive.lin_on, 1'b1)
    wr(fracn_pkg::mod_ctrl_off, 32'h7);
    repeat (3) @(posedge clock);
    `CHK(pump_drive.lin_on, 1'b0)
    wr(fracn_pkg::pump_ctrl_off, 32'h110);
    wait_high(high_clamp_flag, 3000);
    repeat (3) @(posedge clock);
    `CHK(pump_drive.source_on, 1'b0)
    rdchk(fracn_pkg::status_off, 32'h2);
    wr(fracn_pkg::pump_ctrl_off, 32'h220);
    wait_high(low_clamp_flag, 3000);
    repeat (3) @(posedge clock);
    `CHK(pump_drive.sink_on, 1'b0)
    rdchk(fracn_pkg::status_off, 32'h1);
    // Same free-running stimulus twice, senses must swap
    // force and reset bits cleared before locking
    wr(fracn_pkg::pump_ctrl_off, 32'h0);
    wr(fracn_pkg::divide_off, 32'd32);
    for (j = 0; j < 2; j++) begin
      repeat (200) @(posedge clock);
      n_up = 0;
      n_dn = 0;
      repeat (640) @(posedge clock);
      if (j == 0) begin
        s = n_up;
        e = n_dn;
        wr(fracn_pkg::pump_ctrl_off, 32'h8);
      end
    end
    `CHK(n_up, e)
    `CHK(n_dn, s)
    `CHK(s + e > 0, 1'b1)
    ref_free <= 1'b0;
    wr(fracn_pkg::pump_ctrl_off, 32'h0);
    wr(fracn_pkg::numer_off, $urandom_range(262143, 1));
    for (j = 0; j < 3; j++) begin
      r = (j == 0) ? 32 : (j == 1) ? 1023 : $urandom_range(1022, 33);
      wr(fracn_pkg::divide_off, r);
      grab(2);
      grab(3);
      for (i = 0; i < 3; i++) `CHK(per[i], r)
    end
    wr(fracn_pkg::divide_off, 32'd300);
    grab(1);
    repeat ($urandom_range(300, 10)) @(posedge clock);
    wr(fracn_pkg::divide_off, 32'd40);
    grab(3);
    `CHK(per[0] == 300 || per[0] == 40, 1'b1)
    `CHK(per[2], 40)
    // fractional ratios kept within 35 through 1019
    for (j = 0; j < 3; j++) begin
      r = (j == 0) ? 35 : (j == 1) ? 1019 : $urandom_range(200, 35);
      n = (j == 0) ? 131072 : (j == 1) ? 262143 : $urandom_range(262143, 1);
      wr(fracn_pkg::mod_ctrl_off, (j == 2) ? 32'h6 : 32'h4);
      wr(fracn_pkg::divide_off, r);
      wr(fracn_pkg::numer_off, n);
      grab(2);
      grab(16);
      s = per.sum();
      ex = 16.0 * r + 16.0 * n / 262144.0;
      `CHK(s <= ex + 2.0 && s >= ex - 2.0, 1'b1)
    end
    // Each restart must replay the same dithered sequence
    wr(fracn_pkg::divide_off, 32'd50);
    n = $urandom_range(262143, 1);
    s = $urandom_range(262143, 1);
    // Numerator and seed fixed first, so every restart sees the same inputs
    wr(fracn_pkg::numer_off, n);
    wr(fracn_pkg::seed_off, s);
    for (j = 0; j < 3; j++) begin
      if (j == 2) wr(fracn_pkg::mod_ctrl_off, 32'h2);
      grab(1);
      if (j == 0) wr(fracn_pkg::seed_off, s);
      else if (j == 1) wr(fracn_pkg::numer_off, n);
      else wr(fracn_pkg::mod_ctrl_off, 32'ha);
      grab(2);
      grab(10);
      if (j == 0) seqa = per;
      else for (i = 0; i < 10; i++) `CHK(per[i], seqa[i])
    end
    rdchk(fracn_pkg::mod_ctrl_off, 32'h2);
    end_of_test();
  end
endmodule
